//--- core/dac_ctrl_end.sv
`timescale 1ns/1ns
// How it works
// - Strobe rise samples both channels together.
// - Results appear in the next frame.
// - Strobes no faster than about 1.5 MHz.
// - Two 14-bit two's complement words per frame.
// - Exactly 34 serial clocks per strobe.
// - Two released cycles around each word; here four lie between the words and none after word B.
// - Keep clocking until the line is released.
// - Short frames leave the shared line driven.
// - Strobe is a trigger, not a select.
// - Drive all other bus selects high.
// - Parallel flash disabled during reads.
// - Hold the configuration init line high.
// ==========================================================================
// Capture controller: issues strobes, makes the serial clock by division,
// gathers two words per frame and hands them through a two-entry buffer.
module dac_ctrl_end #(
    parameter int unsigned MIN_CYCLES = dac_pkg::MIN_CONV_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    dac_link_if.ctrl         link,
    input  wire logic        start_i,
    input  wire logic        miso_i,
    input  wire logic        ready_i,
    output logic             ready_o,
    output logic             valid_o,
    output logic [13:0]      chan_a_o,
    output logic [13:0]      chan_b_o
);

    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_FRAME, ST_DONE} dac_state_e;

    // ======================================================================
    // Data pin synchroniser.
    logic [1:0] miso_sync_q;
    always_ff @(posedge mclk_i) begin
        miso_sync_q <= {miso_sync_q[0], miso_i};
    end

    // ======================================================================
    // Frame state machine.
    dac_state_e  state_q, state_d;
    logic [7:0]  gap_q, gap_d;
    logic [3:0]  div_q, div_d;
    logic        sck_q, sck_d;
    logic        conv_q, conv_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [13:0] sh_a_q, sh_a_d;
    logic [13:0] sh_b_q, sh_b_d;
    logic        push;
    logic        buf_ready;

    // The strobe is a short pulse, then 34 full serial clocks follow; the
    // clock never stops mid frame so the converter releases the line.
    always_comb begin
        state_d = state_q;
        gap_d   = (gap_q != 8'h00) ? gap_q - 8'h01 : gap_q;
        div_d   = div_q;
        sck_d   = sck_q;
        conv_d  = 1'b0;
        cnt_d   = cnt_q;
        sh_a_d  = sh_a_q;
        sh_b_d  = sh_b_q;
        push    = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_i && gap_q == 8'h00 && buf_ready) begin
                    state_d = ST_STROBE;
                    conv_d  = 1'b1;
                    gap_d   = 8'(MIN_CYCLES);
                    div_d   = 4'h0;
                end
            end
            ST_STROBE: begin
                // Pulse ends before clocking starts.
                state_d = ST_FRAME;
                cnt_d   = dac_pkg::CNT_RST;
                sck_d   = 1'b1;
            end
            ST_FRAME: begin
                if (div_q == 4'(dac_pkg::SCK_HALF_CYCLES - 1)) begin
                    div_d = 4'h0;
                    sck_d = ~sck_q;
                    if (sck_q) begin
                        // Falling edge: the bit put out after the last fall has
                        // crossed both synchronisers by now, so take it here.
                        if (cnt_q >= 6'(dac_pkg::WORD_A_START) &&
                            cnt_q < 6'(dac_pkg::WORD_A_START + dac_pkg::SAMPLE_BITS)) begin
                            sh_a_d = {sh_a_q[12:0], miso_sync_q[1]};
                        end
                        if (cnt_q >= 6'(dac_pkg::WORD_B_START) &&
                            cnt_q < 6'(dac_pkg::WORD_B_START + dac_pkg::SAMPLE_BITS)) begin
                            sh_b_d = {sh_b_q[12:0], miso_sync_q[1]};
                        end
                        cnt_d = cnt_q + 6'h01;
                    end else if (cnt_q == 6'(dac_pkg::FRAME_CYCLES)) begin
                        // The closing rise leaves the clock idle high and comes
                        // after the converter has let go of the line.
                        state_d = ST_DONE;
                    end
                end else begin
                    div_d = div_q + 4'h1;
                end
            end
            ST_DONE: begin
                push    = 1'b1;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Registers for the frame state.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            gap_q   <= 8'h00;
            div_q   <= 4'h0;
            sck_q   <= 1'b1;
            conv_q  <= 1'b0;
            cnt_q   <= dac_pkg::CNT_RST;
            sh_a_q  <= dac_pkg::SAMPLE_RST;
            sh_b_q  <= dac_pkg::SAMPLE_RST;
        end else begin
            state_q <= state_d;
            gap_q   <= gap_d;
            div_q   <= div_d;
            sck_q   <= sck_d;
            conv_q  <= conv_d;
            cnt_q   <= cnt_d;
            sh_a_q  <= sh_a_d;
            sh_b_q  <= sh_b_d;
        end
    end

    // ======================================================================
    // Two-entry result buffer; a stalled receiver holds off new frames.
    logic [27:0] mem_q [2];
    logic [27:0] mem_d [2];
    logic        wp_q, wp_d;
    logic        rp_q, rp_d;
    logic [1:0]  fill_q, fill_d;
    logic        pop;

    assign buf_ready = (fill_q != 2'h2);
    assign pop       = ready_i && (fill_q != 2'h0);

    // Pointers and count advance on push and pop.
    always_comb begin
        mem_d[0] = mem_q[0];
        mem_d[1] = mem_q[1];
        wp_d     = wp_q;
        rp_d     = rp_q;
        fill_d   = fill_q;
        if (push) begin
            mem_d[wp_q] = {sh_a_q, sh_b_q};
            wp_d        = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        fill_d = fill_q + {1'b0, push} - {1'b0, pop};
    end

    // Registers for the buffer.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mem_q[0] <= 28'h0000000;
            mem_q[1] <= 28'h0000000;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            fill_q   <= 2'h0;
        end else begin
            mem_q[0] <= mem_d[0];
            mem_q[1] <= mem_d[1];
            wp_q     <= wp_d;
            rp_q     <= rp_d;
            fill_q   <= fill_d;
        end
    end

    // Output registers follow the buffer head.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            valid_o  <= 1'b0;
            chan_a_o <= dac_pkg::SAMPLE_RST;
            chan_b_o <= dac_pkg::SAMPLE_RST;
            ready_o  <= 1'b0;
        end else begin
            valid_o  <= (fill_d != 2'h0);
            chan_a_o <= mem_d[rp_d][27:14];
            chan_b_o <= mem_d[rp_d][13:0];
            ready_o  <= (state_d == ST_IDLE) && (fill_d != 2'h2) && (gap_d == 8'h00);
        end
    end

    // Link pins; every other bus sharer is held disabled.
    assign link.sck                     = sck_q;
    assign link.conversion_strobe       = conv_q;
    assign link.serial_flash_sel_n      = 1'b1;
    assign link.preamp_select_n         = 1'b1;
    assign link.dac_sel_n               = 1'b1;
    assign link.parallel_flash_enable_n = 1'b1;
    assign link.config_init_n           = 1'b1;

endmodule

//--- core/dac_pkg.sv
// ==========================================================================
// Shared constants for the dual converter capture link.
package dac_pkg;

    // Clock rate of both ends, in kHz.
    localparam int unsigned MCLK_KHZ = 20000;
    // Least strobe period for about 1.5 MHz, in ns.
    localparam int unsigned MIN_CONV_PERIOD_NS = 667;
    // Strobe period in clock cycles, rounded up.
    localparam int unsigned MIN_CONV_CYCLES =
        (MIN_CONV_PERIOD_NS * MCLK_KHZ + 999999) / 1000000;

    // Frame layout in serial clock cycles.
    localparam int unsigned SAMPLE_BITS  = 14;
    localparam int unsigned FRAME_CYCLES = 34;
    localparam int unsigned GAP_CYCLES   = 2;
    // First serial cycle of word A and of word B.
    localparam int unsigned WORD_A_START = GAP_CYCLES;
    localparam int unsigned WORD_B_START = WORD_A_START + SAMPLE_BITS + 2 * GAP_CYCLES;

    // Serial clock half period in system clocks, for the controller divider.
    localparam int unsigned SCK_HALF_CYCLES = 4;

    // Reset values.
    localparam logic [13:0] SAMPLE_RST = 14'h0000;
    localparam logic [5:0]  CNT_RST    = 6'h00;

endpackage

//--- core/dac_link_if.sv
`timescale 1ns/1ns
// ==========================================================================
// Link between the capture controller and the converter.
interface dac_link_if;
    logic sck;                      // Serial clock from the controller.
    logic conversion_strobe;        // Sampling trigger from the controller.
    logic miso_o;                   // Converter data output value.
    logic miso_oe;                  // High while the converter drives data.
    logic serial_flash_sel_n;       // Bus sharer disables, driven high.
    logic preamp_select_n;
    logic dac_sel_n;
    logic parallel_flash_enable_n;
    logic config_init_n;

    modport ctrl (
        output sck,
        output conversion_strobe,
        input  miso_o,
        input  miso_oe,
        output serial_flash_sel_n,
        output preamp_select_n,
        output dac_sel_n,
        output parallel_flash_enable_n,
        output config_init_n
    );

    modport adc (
        input  sck,
        input  conversion_strobe,
        output miso_o,
        output miso_oe
    );
endinterface

//--- core/dac_adc_end.sv
`timescale 1ns/1ns
// ==========================================================================
// Converter end: samples both channels on a strobe and shifts the
// previous results out, each word preceded by released cycles.
module dac_adc_end (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    dac_link_if.adc          link,
    input  wire logic [13:0] chan_a_i,
    input  wire logic [13:0] chan_b_i,
    output logic             busy_o
);

    // ======================================================================
    // Input synchronisers for the link pins.
    logic [1:0] sck_sync_q;
    logic [1:0] conv_sync_q;
    logic       sck_prev_q;
    logic       conv_prev_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            // Idle levels of the pins, so that no false edge follows reset.
            sck_sync_q  <= 2'h3;
            conv_sync_q <= 2'h0;
            sck_prev_q  <= 1'b1;
            conv_prev_q <= 1'b0;
        end else begin
            sck_sync_q  <= {sck_sync_q[0], link.sck};
            conv_sync_q <= {conv_sync_q[0], link.conversion_strobe};
            sck_prev_q  <= sck_sync_q[1];
            conv_prev_q <= conv_sync_q[1];
        end
    end

    logic sck_fall;
    logic conv_rise;
    assign sck_fall  = ~sck_sync_q[1] & sck_prev_q;
    assign conv_rise = conv_sync_q[1] & ~conv_prev_q;

    // ======================================================================
    // Sample holding, output shift and frame counter.
    logic [13:0] samp_a_q, samp_a_d;
    logic [13:0] samp_b_q, samp_b_d;
    logic [27:0] shift_q, shift_d;
    logic [5:0]  cnt_q, cnt_d;
    logic        active_q, active_d;
    logic        data_q, data_d;
    logic        oe_q, oe_d;

    // The frame advances on each serial clock fall; output is held undriven
    // in the gaps so the shared line is released. Samples taken now are only
    // shifted in the next frame.
    always_comb begin
        samp_a_d = samp_a_q;
        samp_b_d = samp_b_q;
        shift_d  = shift_q;
        cnt_d    = cnt_q;
        active_d = active_q;
        data_d   = data_q;
        oe_d     = oe_q;
        if (conv_rise) begin
            samp_a_d = chan_a_i;
            samp_b_d = chan_b_i;
            shift_d  = {samp_a_q, samp_b_q};
            cnt_d    = dac_pkg::CNT_RST;
            active_d = 1'b1;
            oe_d     = 1'b0;
        end else if (active_q && sck_fall) begin
            cnt_d = cnt_q + 6'h01;
            if ((cnt_d >= 6'(dac_pkg::WORD_A_START) &&
                 cnt_d < 6'(dac_pkg::WORD_A_START + dac_pkg::SAMPLE_BITS)) ||
                (cnt_d >= 6'(dac_pkg::WORD_B_START) &&
                 cnt_d < 6'(dac_pkg::WORD_B_START + dac_pkg::SAMPLE_BITS))) begin
                oe_d    = 1'b1;
                data_d  = shift_d[27];
                shift_d = {shift_d[26:0], 1'b0};
            end else begin
                oe_d = 1'b0;
            end
            if (cnt_d == 6'(dac_pkg::FRAME_CYCLES)) begin
                active_d = 1'b0;
                oe_d     = 1'b0;
            end
        end
        // A cut frame leaves the line driven until the clocks resume.
    end

    // Registers for the converter state.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            samp_a_q <= dac_pkg::SAMPLE_RST;
            samp_b_q <= dac_pkg::SAMPLE_RST;
            shift_q  <= {dac_pkg::SAMPLE_RST, dac_pkg::SAMPLE_RST};
            cnt_q    <= dac_pkg::CNT_RST;
            active_q <= 1'b0;
            data_q   <= 1'b0;
            oe_q     <= 1'b0;
        end else begin
            samp_a_q <= samp_a_d;
            samp_b_q <= samp_b_d;
            shift_q  <= shift_d;
            cnt_q    <= cnt_d;
            active_q <= active_d;
            data_q   <= data_d;
            oe_q     <= oe_d;
        end
    end

    assign link.miso_o  = data_q;
    assign link.miso_oe = oe_q;
    assign busy_o       = active_q;

endmodule

//--- verif/dac_chk.sv
`timescale 1ns/1ns
// ==========================================================================
// Link watcher: framing, release and select rules between the two ends.
module dac_chk #(
    parameter int unsigned MIN_CYCLES = dac_pkg::MIN_CONV_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sck,
    input wire logic conversion_strobe,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic serial_flash_sel_n,
    input wire logic preamp_select_n,
    input wire logic dac_sel_n,
    input wire logic parallel_flash_enable_n,
    input wire logic config_init_n
);
    logic       sck_q;
    logic       seen_q;
    logic [5:0] falls_q;
    logic [5:0] bits_q;
    logic [9:0] gap_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Counts serial falls, driven rises and spacing since the last strobe.
    always_ff @(posedge mclk_i) begin
        sck_q <= sck;
        if (rst_i) begin
            seen_q  <= 1'b0;
            falls_q <= 6'h00;
            bits_q  <= 6'h00;
            gap_q   <= 10'h000;
        end else if (conversion_strobe) begin
            seen_q  <= 1'b1;
            falls_q <= 6'h00;
            bits_q  <= 6'h00;
            gap_q   <= 10'h001;
        end else begin
            if (sck_q && !sck) falls_q <= falls_q + 6'h01;
            if (!sck_q && sck && miso_oe) bits_q <= bits_q + 6'h01;
            if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
        end
    end

    sequence strobe_s;
        conversion_strobe;
    endsequence
    sequence first_fall_s;
        ##[1:12] (sck_q && !sck);
    endsequence

    selects_high_a: assert property (&{serial_flash_sel_n, preamp_select_n, dac_sel_n,
        parallel_flash_enable_n, config_init_n}) else $error("bus sharer enabled");
    strobe_pulse_a: assert property (strobe_s |=> !conversion_strobe)
        else $error("strobe longer than one cycle");
    strobe_idle_a: assert property (strobe_s |-> sck)
        else $error("strobe while serial clock low");
    strobe_space_a: assert property (strobe_s and seen_q |-> gap_q >= MIN_CYCLES)
        else $error("strobes too close");
    frame_count_a: assert property (strobe_s and seen_q |->
        falls_q == 6'(dac_pkg::FRAME_CYCLES))
        else $error("frame clock count wrong");
    word_bits_a: assert property (strobe_s and seen_q |->
        bits_q == 6'(2 * dac_pkg::SAMPLE_BITS))
        else $error("driven bit count wrong");
    lead_release_a: assert property (falls_q < 6'(dac_pkg::GAP_CYCLES) |-> !miso_oe)
        else $error("data driven before word");
    idle_release_a: assert property (sck [*8] |-> !miso_oe)
        else $error("data driven while link idle");
    frame_start_a: assert property (strobe_s |-> first_fall_s)
        else $error("no serial clock after strobe");
    data_hold_a: assert property (sck && sck_q |-> $stable(miso_o))
        else $error("data changed while clock high");
endmodule

//--- verif/dual_adc_sample_capture_tb_top.sv
`timescale 1ns/1ns
// ==========================================================================
// Bench: both ends joined, plus a lone converter end for a cut frame.
module dual_adc_sample_capture_tb_top;
    logic        mclk_i     = 1'b0;
    logic        rst_i      = 1'b1;
    logic        start_i    = 1'b0;
    logic        ready_i    = 1'b0;
    logic [13:0] chan_a_i   = 14'h0000;
    logic [13:0] chan_b_i   = 14'h0000;
    logic        float_q    = 1'b0;
    logic        miso_w;
    logic        ready_o;
    logic        valid_o;
    logic        busy_o;
    logic        cut_busy_o;
    logic [13:0] chan_a_o;
    logic [13:0] chan_b_o;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    dac_link_if lnk ();
    dac_link_if cut_lnk ();

    // A released line shows a changing pattern, never a held value.
    assign miso_w = lnk.miso_oe ? lnk.miso_o : float_q;

    dac_ctrl_end #(.MIN_CYCLES(14)) i_dac_ctrl_end (.mclk_i(mclk_i), .rst_i(rst_i),
        .link(lnk.ctrl), .start_i(start_i), .miso_i(miso_w), .ready_i(ready_i),
        .ready_o(ready_o), .valid_o(valid_o), .chan_a_o(chan_a_o), .chan_b_o(chan_b_o));
    dac_adc_end i_dac_adc_end (.mclk_i(mclk_i), .rst_i(rst_i), .link(lnk.adc),
        .chan_a_i(chan_a_i), .chan_b_i(chan_b_i), .busy_o(busy_o));
    dac_adc_end i_dac_adc_end_cut (.mclk_i(mclk_i), .rst_i(rst_i), .link(cut_lnk.adc),
        .chan_a_i(chan_a_i), .chan_b_i(chan_b_i), .busy_o(cut_busy_o));
    dac_chk #(.MIN_CYCLES(14)) i_dac_chk (.mclk_i(mclk_i), .rst_i(rst_i), .sck(lnk.sck),
        .conversion_strobe(lnk.conversion_strobe), .miso_o(lnk.miso_o),
        .miso_oe(lnk.miso_oe), .serial_flash_sel_n(lnk.serial_flash_sel_n),
        .preamp_select_n(lnk.preamp_select_n), .dac_sel_n(lnk.dac_sel_n),
        .parallel_flash_enable_n(lnk.parallel_flash_enable_n),
        .config_init_n(lnk.config_init_n));

    // System clock of 50 ns.
    always #25 mclk_i = ~mclk_i;

    // Float pattern and hang guard.
    always @(posedge mclk_i) begin
        float_q <= ~float_q;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask

    // Starts a frame that samples a and b, then disturbs the inputs.
    task automatic start_frame(input logic [13:0] a, input logic [13:0] b);
        chan_a_i = a;
        chan_b_i = b;
        for (int i = 0; i < 1000 && ready_o !== 1'b1; i++) tick();
        start_i = 1'b1;
        tick();
        start_i = 1'b0;
        for (int i = 0; i < 10 && lnk.conversion_strobe !== 1'b1; i++) tick();
        // The converter takes its samples once the strobe has crossed its synchroniser.
        repeat (4) tick();
        chan_a_i = ~a;
        chan_b_i = ~b;
        check("ready_busy", ready_o, 14'h0000);
    endtask

    // Takes one word pair off the buffer head.
    task automatic pop_word(input logic [13:0] ea, input logic [13:0] eb);
        for (int i = 0; i < 1000 && valid_o !== 1'b1; i++) tick();
        check("chan_a", chan_a_o, ea);
        check("chan_b", chan_b_o, eb);
        ready_i = 1'b1;
        tick();
        ready_i = 1'b0;
    endtask

    task automatic reset_state();
        check("valid_rst", valid_o, 14'h0000);
        check("ready_in_rst", ready_o, 14'h0000);
        // Ready comes up at the first edge after reset is released.
        tick();
        check("ready_rst", ready_o, 14'h0001);
        check("pflash_off", lnk.parallel_flash_enable_n, 14'h0001);
    endtask

    // Two frames under stall fill the buffer; a third start is refused.
    task automatic latency_and_order();
        start_frame(14'h1fff, 14'h2000);
        start_frame(14'h2a5c, 14'h15a3);
        for (int i = 0; i < 1000 && busy_o !== 1'b0; i++) tick();
        repeat (20) tick();
        check("ready_full", ready_o, 14'h0000);
        start_i = 1'b1;
        for (int i = 0; i < 20; i++) begin
            tick();
            check("no_strobe", lnk.conversion_strobe, 14'h0000);
        end
        start_i = 1'b0;
        pop_word(dac_pkg::SAMPLE_RST, dac_pkg::SAMPLE_RST);
        pop_word(14'h1fff, 14'h2000);
        start_frame(14'h0001, 14'h3ffe);
        pop_word(14'h2a5c, 14'h15a3);
    endtask

    // A frame cut after ten clocks leaves the lone converter driving.
    task automatic cut_frame();
        cut_lnk.conversion_strobe = 1'b1;
        tick();
        cut_lnk.conversion_strobe = 1'b0;
        repeat (10) begin
            repeat (4) tick();
            cut_lnk.sck = 1'b0;
            repeat (4) tick();
            cut_lnk.sck = 1'b1;
        end
        repeat (40) tick();
        check("cut_oe", cut_lnk.miso_oe, 14'h0001);
        check("cut_busy", cut_busy_o, 14'h0001);
    endtask

    // Main sequence.
    initial begin
        cut_lnk.sck = 1'b1;
        cut_lnk.conversion_strobe = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        reset_state();
        cut_frame();
        latency_and_order();
        tally_and_finish();
    end
endmodule
